// >>> cid_pkg.sv
// Purpose: Shared constants for the instruction compliance decoder.
// Assumes: Big-endian bit numbering of the ISA is mapped to [31:0] as bit 0 = MSB.
// Notes: Register offsets are byte addresses on a classic Wishbone slave.
//
// What this block does
// - Only 32-bit behaviour; 64-bit opcodes emulated.
// - Reserved instruction fields ignored, taken as zero.
// - Reserved control register bits: discard, read zero.
// - Cause bits 16:23 and state reserved bits stored.
// - Optional instructions except store-as-integer trap 0x01000.
// - Illegal and reserved opcodes trap to emulation.
// - Every instruction exception is precise.
// - Don't-care branch option bits ignored.
// - Count-register branch with decrement targets new counter.
// - Hint predicts unresolved conditions; unresolved targets unpredicted.
// - Unimplemented privileged special register in user traps.
// - Divide overflow gives 0x80000000 and fixed flags.
// - Compare length bit ignored.
// - Update form with base zero writes address.
// - Load/store multiple needs word alignment.
// - Multiple load reloads base from offset address.
// - String load reloads base like multiple.
// - Reservation instructions need word alignment.
// - Single load of denormal takes assist.
// - Single store exponent 1..896 takes assist.
// - Zero and double denormals store signed zero.
// - Little-endian unaligned, multiple, string take alignment.
`default_nettype none
package cid_pkg;
   // ==========================================================
   // Register map
   localparam logic [7:0]  ADR_FXCR  = 8'h00;
   localparam logic [7:0]  ADR_MST   = 8'h04;
   localparam logic [7:0]  ADR_STAT  = 8'h08;
   localparam logic [31:0] FXCR_MASK = 32'he000ff7f;
   localparam logic [31:0] FXCR_RST  = 32'h00000000;
   localparam logic [31:0] MST_RST   = 32'h00000000;
   localparam int          FXCR_SO   = 31;
   localparam int          FXCR_OV   = 30;
   localparam int          MST_LE    = 0;
   localparam int          MST_PR    = 14;
   // ==========================================================
   // Exception vector offsets
   localparam logic [19:0] VEC_NONE  = 20'h00000;
   localparam logic [19:0] VEC_ALIGN = 20'h00600;
   localparam logic [19:0] VEC_PROG  = 20'h00700;
   localparam logic [19:0] VEC_FPA   = 20'h00e00;
   localparam logic [19:0] VEC_EMU   = 20'h01000;
   // ==========================================================
   // Opcodes
   localparam logic [5:0] OP_CMPLI = 6'h0a;
   localparam logic [5:0] OP_CMPI  = 6'h0b;
   localparam logic [5:0] OP_BC    = 6'h10;
   localparam logic [5:0] OP_XL    = 6'h13;
   localparam logic [5:0] OP_X     = 6'h1f;
   localparam logic [5:0] OP_LDM   = 6'h2e;
   localparam logic [5:0] OP_STM   = 6'h2f;
   localparam logic [5:0] OP_LFS   = 6'h30;
   localparam logic [5:0] OP_LFSU  = 6'h31;
   localparam logic [5:0] OP_STFS  = 6'h34;
   localparam logic [5:0] OP_STFSU = 6'h35;
   localparam logic [5:0] OP_UPD_LO = 6'h21;
   localparam logic [5:0] OP_UPD_HI = 6'h37;
   localparam logic [5:0] OP_FPS   = 6'h3b;
   localparam logic [5:0] OP_FPD   = 6'h3f;
   localparam logic [9:0] XO_BCLR  = 10'h010;
   localparam logic [9:0] XO_BCCTR = 10'h210;
   localparam logic [9:0] XO_CMP   = 10'h000;
   localparam logic [9:0] XO_CMPL  = 10'h020;
   localparam logic [8:0] XO_DIVW  = 9'h1eb;
   localparam logic [9:0] XO_MTSPR = 10'h1d3;
   localparam logic [9:0] XO_MFSPR = 10'h153;
   localparam logic [9:0] XO_LWARX = 10'h014;
   localparam logic [9:0] XO_STWCX = 10'h096;
   localparam logic [9:0] XO_LSWI  = 10'h255;
   localparam logic [9:0] XO_LSWX  = 10'h215;
   localparam logic [9:0] XO_STSWI = 10'h2d5;
   localparam logic [9:0] XO_STSWX = 10'h295;
   localparam logic [9:0] XO_ECIWX = 10'h136;
   localparam logic [9:0] XO_ECOWX = 10'h1b6;
   localparam logic [9:0] XO_TLBIE = 10'h132;
   localparam logic [9:0] XO_TLBIA = 10'h172;
   localparam logic [9:0] XO_TSYNC = 10'h236;
   localparam logic [4:0] A_FSQRT  = 5'h16;
   localparam logic [4:0] A_FSEL   = 5'h17;
   localparam logic [4:0] A_FRES   = 5'h18;
   localparam logic [4:0] A_FRSQRT = 5'h1a;
   // ==========================================================
   // Arithmetic corner values
   localparam logic [31:0] DIV_OVF_RES = 32'h80000000;
   localparam logic [31:0] MINUS_ONE   = 32'hffffffff;
   localparam logic [10:0] FP_DEN_MAX  = 11'h380;
endpackage
`default_nettype wire

// >>> cid_decode.sv
// Purpose: Decode-stage compliance logic: traps, branch, divide, compare, load/store corners.
// Assumes: One instruction per instr_v_i pulse; results appear one cycle later.
// Notes: Control registers sit behind a classic Wishbone slave.
//
// Our own choices: register access over Wishbone and the address map.
`timescale 1ns/1ps
`default_nettype none
module cid_decode
   import cid_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic             wb_ack_o,
   output logic      [31:0] wb_dat_o,
   input  wire logic        instr_v_i,
   input  wire logic [31:0] instr_i,
   input  wire logic [31:0] pc_i,
   input  wire logic [31:0] ea_i,
   input  wire logic [31:0] opa_i,
   input  wire logic [31:0] opb_i,
   input  wire logic [31:0] loopc_i,
   input  wire logic [31:0] lr_i,
   input  wire logic [31:0] cfield_i,
   input  wire logic        cond_rdy_i,
   input  wire logic        tgt_rdy_i,
   input  wire logic [31:0] ld_data_i,
   input  wire logic [63:0] fpsrc_i,
   output logic             done_o,
   output logic             exc_o,
   output logic      [19:0] exc_vec_o,
   output logic             res_we_o,
   output logic      [31:0] res_o,
   output logic             flag_we_o,
   output logic      [2:0]  flag_fld_o,
   output logic      [3:0]  flag_o,
   output logic             br_v_o,
   output logic             br_taken_o,
   output logic      [31:0] br_tgt_o,
   output logic             loopc_we_o,
   output logic      [31:0] loopc_o,
   output logic             pred_v_o,
   output logic             pred_taken_o,
   output logic             g0_we_o,
   output logic      [31:0] g0_o,
   output logic             bload_v_o,
   output logic      [31:0] bload_adr_o,
   output logic             fst_we_o,
   output logic      [31:0] fst_o
);
   import cid_pkg::*;

   typedef struct packed {
      logic        ack;
      logic [31:0] rdat;
      logic [31:0] fxcr;
      logic [31:0] mst;
      logic [19:0] last_vec;
      logic        done;
      logic        exc;
      logic [19:0] vec;
      logic        res_we;
      logic [31:0] res;
      logic        flag_we;
      logic [2:0]  fld;
      logic [3:0]  flag;
      logic        br_v;
      logic        br_taken;
      logic [31:0] br_tgt;
      logic        lc_we;
      logic [31:0] lc;
      logic        pred_v;
      logic        pred_taken;
      logic        g0_we;
      logic [31:0] g0;
      logic        bl_v;
      logic [31:0] bl_adr;
      logic        fst_we;
      logic [31:0] fst;
   } cid_state_t;

   cid_state_t q;
   cid_state_t d;

   // ==========================================================
   // Field extraction; only defined fields feed the decode.
   logic [5:0]  op;
   logic [4:0]  tgt;
   logic [4:0]  base;
   logic [4:0]  fb;
   logic [9:0]  xo;
   logic [4:0]  axo;
   logic        is_x;
   logic        user;
   logic        le;
   logic [31:0] bmask;

   assign op   = instr_i[31:26];
   assign tgt  = instr_i[25:21];
   assign base = instr_i[20:16];
   assign fb   = instr_i[15:11];
   assign xo   = instr_i[10:1];
   assign axo  = instr_i[5:1];
   assign is_x = (op == OP_X);
   assign user = q.mst[MST_PR];
   assign le   = q.mst[MST_LE];

   // Byte-lane write mask from the Wishbone selects.
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_lane
         assign bmask[8*gi +: 8] = {8{wb_sel_i[gi]}};
      end
   endgenerate

   // ==========================================================
   // Instruction classes that trap to software emulation.
   logic rsv_op;
   logic opt_op;

   always_comb
   begin
      unique case (op)
         6'h00, 6'h01, 6'h02, 6'h04, 6'h05, 6'h06, 6'h09, 6'h16,
         6'h1e, 6'h38, 6'h39, 6'h3a, 6'h3c, 6'h3d, 6'h3e:
            rsv_op = 1'b1;
         default:
            rsv_op = 1'b0;
      endcase
   end

   // The store-as-integer form is deliberately absent from this list.
   assign opt_op = ((op == OP_FPS) && (axo == A_FSQRT || axo == A_FRES))
      || ((op == OP_FPD) && (axo == A_FSQRT || axo == A_FSEL || axo == A_FRSQRT))
      || (is_x && (xo == XO_ECIWX || xo == XO_ECOWX || xo == XO_TLBIE
      || xo == XO_TLBIA || xo == XO_TSYNC));

   // ==========================================================
   // Special register moves.
   logic [9:0] sprn;
   logic       spr_mv;
   logic       spr_known;

   assign sprn   = {fb, base};
   assign spr_mv = is_x && (xo == XO_MTSPR || xo == XO_MFSPR);

   always_comb
   begin
      unique case (sprn)
         10'd1, 10'd8, 10'd9, 10'd18, 10'd19, 10'd22, 10'd26, 10'd27,
         10'd268, 10'd269, 10'd272, 10'd273, 10'd274, 10'd275, 10'd287:
            spr_known = 1'b1;
         default:
            spr_known = 1'b0;
      endcase
   end

   // ==========================================================
   // Branch decode.
   logic [4:0]  bopt;
   logic        is_bc;
   logic        is_bclr;
   logic        is_bcctr;
   logic [31:0] lc_dec;
   logic [31:0] lc_new;
   logic        lc_ok;
   logic        cond_ok;
   logic [31:0] bdisp;
   logic [31:0] btgt;
   logic        reg_br;

   assign bopt     = tgt;
   assign is_bc    = (op == OP_BC);
   assign is_bclr  = (op == OP_XL) && (xo == XO_BCLR);
   assign is_bcctr = (op == OP_XL) && (xo == XO_BCCTR);
   assign reg_br   = is_bclr | is_bcctr;
   assign lc_dec   = loopc_i - 32'h00000001;
   assign lc_new   = bopt[2] ? loopc_i : lc_dec;
   // Only the meaningful option bits are read.
   assign lc_ok    = bopt[2] | ((lc_dec != 32'h0) ^ bopt[1]);
   assign cond_ok  = bopt[4] | (cfield_i[5'd31 - base] == bopt[3]);
   assign bdisp    = {{16{instr_i[15]}}, instr_i[15:2], 2'b00};

   always_comb
   begin
      if (is_bc)
         btgt = (instr_i[1] ? 32'h0 : pc_i) + bdisp;
      else if (is_bclr)
         btgt = {lr_i[31:2], 2'b00};
      else
         btgt = {lc_new[31:2], 2'b00};
   end

   // ==========================================================
   // Compare and divide.
   logic        is_cmp;
   logic        cmp_sgn;
   logic [31:0] cmp_b;
   logic        c_less;
   logic        c_more;
   logic        is_div;
   logic        div_ovf;
   logic [31:0] div_b;
   logic [31:0] quot;
   logic        so_new;

   // The length bit instr_i[21] is never examined.
   assign is_cmp  = (op == OP_CMPI) || (op == OP_CMPLI)
      || (is_x && (xo == XO_CMP || xo == XO_CMPL));
   assign cmp_sgn = (op == OP_CMPI) || (is_x && xo == XO_CMP);
   assign cmp_b   = (op == OP_CMPI) ? {{16{instr_i[15]}}, instr_i[15:0]}
      : (op == OP_CMPLI) ? {16'h0, instr_i[15:0]} : opb_i;
   assign c_less  = cmp_sgn ? ($signed(opa_i) < $signed(cmp_b)) : (opa_i < cmp_b);
   assign c_more  = cmp_sgn ? ($signed(opa_i) > $signed(cmp_b)) : (opa_i > cmp_b);

   assign is_div  = is_x && (instr_i[9:1] == XO_DIVW);
   assign div_ovf = (opb_i == 32'h0)
      || (opa_i == DIV_OVF_RES && opb_i == MINUS_ONE);
   assign div_b   = (opb_i == 32'h0) ? 32'h00000001 : opb_i;
   assign quot    = div_ovf ? DIV_OVF_RES
      : 32'($signed(opa_i) / $signed(div_b));
   assign so_new  = q.fxcr[FXCR_SO] | (instr_i[10] & div_ovf);

   // ==========================================================
   // Load/store classification.
   logic       is_ldm;
   logic       is_stm;
   logic       is_lsw;
   logic       is_str;
   logic       is_sync;
   logic       upd;
   logic       scalar;
   logic [2:0] amask;
   logic       misal;
   logic       word_mis;
   logic [4:0] boff;
   logic [7:0] nbytes;
   logic [5:0] nregs;
   logic       str_hit;
   logic       ldm_hit;
   logic [10:0] fexp;
   logic       st_den;
   logic       ld_den;

   assign is_ldm  = (op == OP_LDM);
   assign is_stm  = (op == OP_STM);
   assign is_lsw  = is_x && (xo == XO_LSWI || xo == XO_LSWX);
   assign is_str  = is_lsw || (is_x && (xo == XO_STSWI || xo == XO_STSWX));
   assign is_sync = is_x && (xo == XO_LWARX || xo == XO_STWCX);
   assign upd     = (op >= OP_UPD_LO) && (op <= OP_UPD_HI) && op[0] && !is_stm;
   assign scalar  = (op >= OP_UPD_LO - 6'h01) && (op <= OP_UPD_HI)
      && !is_ldm && !is_stm;

   always_comb
   begin
      unique case (op[5:1])
         5'h10, 5'h12, 5'h18, 5'h1a:
            amask = 3'h3;
         5'h14, 5'h15, 5'h16:
            amask = 3'h1;
         5'h19, 5'h1b:
            amask = 3'h7;
         default:
            amask = 3'h0;
      endcase
   end

   assign misal    = scalar && ((ea_i[2:0] & amask) != 3'h0);
   assign word_mis = (ea_i[1:0] != 2'b00);
   assign boff     = base - tgt;
   assign nbytes   = (xo == XO_LSWI) ? ((fb == 5'h0) ? 8'h20 : {3'h0, fb})
      : {1'b0, q.fxcr[6:0]};
   assign nregs    = 6'((nbytes + 8'h03) >> 2);
   assign str_hit  = is_lsw && ({1'b0, boff} < nregs);
   assign ldm_hit  = is_ldm && (base >= tgt);

   assign fexp   = fpsrc_i[62:52];
   assign st_den = (fexp != 11'h0) && (fexp <= FP_DEN_MAX);
   assign ld_den = (ld_data_i[30:23] == 8'h0) && (ld_data_i[22:0] != 23'h0);

   // ==========================================================
   // Exception priority: emulation, privilege, alignment, assist.
   logic        trap;
   logic [19:0] tvec;

   always_comb
   begin
      trap = 1'b1;
      if (rsv_op || opt_op)
         tvec = VEC_EMU;
      else if (spr_mv && !spr_known && instr_i[15] && user)
         tvec = VEC_PROG;
      else if (((is_ldm || is_stm || is_sync) && word_mis)
         || (le && (is_ldm || is_stm || is_str || misal)))
         tvec = VEC_ALIGN;
      else if (((op == OP_LFS || op == OP_LFSU) && ld_den)
         || ((op == OP_STFS || op == OP_STFSU) && st_den))
         tvec = VEC_FPA;
      else
      begin
         trap = 1'b0;
         tvec = VEC_NONE;
      end
   end

   // ==========================================================
   // Next state.
   always_comb
   begin
      d = q;
      d.ack = wb_cyc_i && wb_stb_i && !q.ack;
      if (d.ack)
      begin
         unique case (wb_adr_i)
            ADR_FXCR: d.rdat = q.fxcr;
            ADR_MST:  d.rdat = q.mst;
            ADR_STAT: d.rdat = {12'h0, q.last_vec};
            default:  d.rdat = 32'h0;
         endcase
         if (wb_we_i && wb_adr_i == ADR_FXCR)
            d.fxcr = (q.fxcr & ~bmask)
               | (wb_dat_i & bmask & FXCR_MASK);
         if (wb_we_i && wb_adr_i == ADR_MST)
            d.mst = (q.mst & ~bmask) | (wb_dat_i & bmask);
      end
      d.done     = instr_v_i;
      d.exc      = 1'b0;
      d.vec      = VEC_NONE;
      d.res_we   = 1'b0;
      d.flag_we  = 1'b0;
      d.br_v     = 1'b0;
      d.br_taken = 1'b0;
      d.lc_we    = 1'b0;
      d.pred_v   = 1'b0;
      d.pred_taken = 1'b0;
      d.g0_we    = 1'b0;
      d.bl_v     = 1'b0;
      d.fst_we   = 1'b0;
      if (instr_v_i && trap)
      begin
         // A trapping instruction leaves no architectural effect.
         d.exc      = 1'b1;
         d.vec      = tvec;
         d.last_vec = tvec;
      end
      else if (instr_v_i)
      begin
         if (is_bc || reg_br)
         begin
            d.br_v     = 1'b1;
            d.br_taken = lc_ok && cond_ok;
            d.br_tgt   = btgt;
            d.lc_we    = !bopt[2];
            d.lc       = lc_dec;
            d.pred_v   = !bopt[4] && !cond_rdy_i
               && !(reg_br && !tgt_rdy_i);
            d.pred_taken = bopt[0] ^ (is_bc & instr_i[15]);
         end
         if (is_cmp)
         begin
            d.flag_we = 1'b1;
            d.fld     = instr_i[25:23];
            d.flag    = {c_less, c_more, !c_less && !c_more, q.fxcr[FXCR_SO]};
         end
         if (is_div)
         begin
            d.res_we  = 1'b1;
            d.res     = quot;
            d.flag_we = instr_i[0];
            d.fld     = 3'h0;
            d.flag    = div_ovf ? {3'b100, so_new}
               : {quot[31], !quot[31] && quot != 32'h0,
                  quot == 32'h0, so_new};
            if (instr_i[10])
            begin
               d.fxcr[FXCR_OV] = div_ovf;
               d.fxcr[FXCR_SO] = so_new;
            end
         end
         if (upd && base == 5'h0)
         begin
            d.g0_we = 1'b1;
            d.g0    = ea_i;
         end
         if (ldm_hit || str_hit)
         begin
            d.bl_v   = 1'b1;
            d.bl_adr = ea_i + {25'h0, boff, 2'b00};
         end
         if (op == OP_STFS || op == OP_STFSU)
         begin
            d.fst_we = 1'b1;
            d.fst    = (fexp == 11'h0) ? {fpsrc_i[63], 31'h0}
               : {fpsrc_i[63], fpsrc_i[62], fpsrc_i[58:52], fpsrc_i[51:29]};
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         q      <= '0;
         q.fxcr <= FXCR_RST;
         q.mst  <= MST_RST;
      end
      else
         q <= d;
   end

   // ==========================================================
   // Outputs.
   assign wb_ack_o     = q.ack;
   assign wb_dat_o     = q.rdat;
   assign done_o       = q.done;
   assign exc_o        = q.exc;
   assign exc_vec_o    = q.vec;
   assign res_we_o     = q.res_we;
   assign res_o        = q.res;
   assign flag_we_o    = q.flag_we;
   assign flag_fld_o   = q.fld;
   assign flag_o       = q.flag;
   assign br_v_o       = q.br_v;
   assign br_taken_o   = q.br_taken;
   assign br_tgt_o     = q.br_tgt;
   assign loopc_we_o   = q.lc_we;
   assign loopc_o      = q.lc;
   assign pred_v_o     = q.pred_v;
   assign pred_taken_o = q.pred_taken;
   assign g0_we_o      = q.g0_we;
   assign g0_o         = q.g0;
   assign bload_v_o    = q.bl_v;
   assign bload_adr_o  = q.bl_adr;
   assign fst_we_o     = q.fst_we;
   assign fst_o        = q.fst;
endmodule
`default_nettype wire

// >>> cid_sva.sv
// Purpose: Concurrent checks on the decoder's instruction port.
// Assumes: Outputs answer one cycle after instr_v_i.
// Notes: Bound to the decoder from the bench top file.
`timescale 1ns/1ps
`default_nettype none
module cid_sva
   import cid_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        instr_v_i,
   input wire logic [31:0] instr_i,
   input wire logic [31:0] ea_i,
   input wire logic [31:0] opb_i,
   input wire logic [31:0] loopc_i,
   input wire logic        cond_rdy_i,
   input wire logic        tgt_rdy_i,
   input wire logic [63:0] fpsrc_i,
   input wire logic        done_o,
   input wire logic        exc_o,
   input wire logic [19:0] exc_vec_o,
   input wire logic        res_we_o,
   input wire logic [31:0] res_o,
   input wire logic        flag_we_o,
   input wire logic        br_v_o,
   input wire logic        br_taken_o,
   input wire logic [31:0] br_tgt_o,
   input wire logic        loopc_we_o,
   input wire logic [31:0] loopc_o,
   input wire logic        pred_v_o,
   input wire logic        g0_we_o,
   input wire logic [31:0] g0_o,
   input wire logic        fst_we_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ==========================================================
   // Instruction port checks
   property p_done;
      instr_v_i |=> done_o;
   endproperty
   a_done: assert property (p_done) else $error("no done pulse");
   property p_precise;
      exc_o |-> !(res_we_o || flag_we_o || br_v_o || loopc_we_o || g0_we_o || fst_we_o);
   endproperty
   a_precise: assert property (p_precise) else $error("write beside trap");
   property p_illegal;
      instr_v_i && instr_i[31:26] == 6'h00 |=> exc_o && exc_vec_o == VEC_EMU;
   endproperty
   a_illegal: assert property (p_illegal) else $error("illegal not emulated");
   property p_div;
      instr_v_i && instr_i[31:26] == OP_X && instr_i[9:1] == XO_DIVW && opb_i == 32'h0
         |=> res_we_o && res_o == DIV_OVF_RES;
   endproperty
   a_div: assert property (p_div) else $error("divide by zero result");
   property p_align;
      instr_v_i && instr_i[31:26] == OP_LDM && ea_i[1:0] != 2'h0
         |=> exc_o && exc_vec_o == VEC_ALIGN;
   endproperty
   a_align: assert property (p_align) else $error("multiple not aligned");
   property p_lcnt;
      instr_v_i && instr_i[31:26] == OP_XL && instr_i[10:1] == XO_BCCTR && !instr_i[23]
         |=> loopc_we_o && loopc_o == $past(loopc_i) - 32'h1
             && (!br_taken_o || br_tgt_o == {loopc_o[31:2], 2'h0});
   endproperty
   a_lcnt: assert property (p_lcnt) else $error("counter branch target");
   property p_pred;
      instr_v_i && cond_rdy_i && tgt_rdy_i |=> !pred_v_o;
   endproperty
   a_pred: assert property (p_pred) else $error("resolved branch predicted");
   property p_g0;
      instr_v_i && instr_i[31:26] == 6'h21 && instr_i[20:16] == 5'h0 && ea_i[1:0] == 2'h0
         |=> g0_we_o && g0_o == $past(ea_i);
   endproperty
   a_g0: assert property (p_g0) else $error("update base zero");
   property p_sden;
      instr_v_i && instr_i[31:26] == OP_STFS && ea_i[1:0] == 2'h0 && fpsrc_i[62:52] != 11'h0
         && fpsrc_i[62:52] <= FP_DEN_MAX |=> exc_o && exc_vec_o == VEC_FPA;
   endproperty
   a_sden: assert property (p_sden) else $error("single store assist");
endmodule
`default_nettype wire

// >>> tb_top.sv
// Purpose: Self-checking bench for the compliance decoder.
// Assumes: Results are sampled one cycle after each instruction.
// Notes: Instruction words are built from field concatenations.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import cid_pkg::*;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        wb_cyc_i = 1'b0;
   logic        wb_stb_i = 1'b0;
   logic        wb_we_i = 1'b0;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [3:0]  wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic        instr_v_i = 1'b0;
   logic        cond_rdy_i = 1'b0;
   logic        tgt_rdy_i = 1'b0;
   logic [31:0] instr_i = 32'h0, pc_i = 32'h1000, ea_i = 32'h0, opa_i = 32'h0, opb_i = 32'h0;
   logic [31:0] loopc_i = 32'h0, lr_i = 32'h0, cfield_i = 32'h0, ld_data_i = 32'h0;
   logic [63:0] fpsrc_i = 64'h0;
   logic        wb_ack_o, done_o, exc_o, res_we_o, flag_we_o, br_v_o, br_taken_o, loopc_we_o;
   logic        pred_v_o, pred_taken_o, g0_we_o, bload_v_o, fst_we_o;
   logic [31:0] wb_dat_o, res_o, br_tgt_o, loopc_o, g0_o, bload_adr_o, fst_o, rd;
   logic [19:0] exc_vec_o;
   logic [2:0]  flag_fld_o;
   logic [3:0]  flag_o;
   logic [31:0] emu_tab [7];
   logic [95:0] fp_tab [5];
   logic [35:0] pr_tab [4];
   int          i;
   int          n_fail = 0;
   int          samples_checked = 0;

   cid_decode dut_u (.*);

   always #2.5 clk_i = ~clk_i;

   // ==========================================================
   // Access tasks
   task automatic chk(input logic [63:0] act, input logic [63:0] exp);
      samples_checked++;
      if (act !== exp)
      begin
         n_fail++;
         $display("[ERR] t=%0t got %h exp %h", $time, act, exp);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= 4'hf;
      do
         @(posedge clk_i);
      while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic run(input logic [31:0] ins, input logic [31:0] ea, input logic [31:0] a,
                      input logic [31:0] b, input logic [63:0] x, input logic [1:0] rdy);
      @(posedge clk_i);
      instr_v_i <= 1'b1;
      instr_i   <= ins;
      ea_i      <= ea;
      opa_i     <= a;
      opb_i     <= b;
      cfield_i  <= a;
      loopc_i   <= x[31:0];
      ld_data_i <= x[31:0];
      lr_i      <= x[63:32];
      fpsrc_i   <= x;
      {cond_rdy_i, tgt_rdy_i} <= rdy;
      @(posedge clk_i);
      instr_v_i <= 1'b0;
      @(negedge clk_i);
   endtask
   task automatic ex(input logic [19:0] v);
      chk({done_o, exc_o, exc_vec_o}, {2'b11, v});
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // ==========================================================
   // Test sequence
   initial
   begin
      emu_tab = '{32'h0, {OP_FPD, 20'h0, A_FSQRT, 1'b0}, {OP_FPS, 20'h0, A_FRES, 1'b0},
                  {OP_FPD, 20'h0, A_FSEL, 1'b0}, {OP_X, 15'h0, XO_TLBIE, 1'b0},
                  {OP_X, 15'h0, XO_ECIWX, 1'b0}, {6'h3a, 26'h0}};
      fp_tab = '{{64'h0010000000000000, 32'h0}, {1'b0, FP_DEN_MAX, 52'h0, 32'h0},
                 {1'b0, 11'h381, 52'h0, 32'h00800000}, {64'h8000000000000000, 32'h80000000},
                 {64'h1, 32'h0}};
      pr_tab = '{{OP_BC, 5'h04, 5'h0, 14'h3fff, 2'h0, 4'h7}, {OP_BC, 5'h05, 5'h0, 14'h3fff,
                 2'h0, 4'h6}, {OP_BC, 5'h04, 5'h0, 14'h3fff, 2'h0, 4'hc},
                 {OP_XL, 5'h04, 10'h0, XO_BCLR, 1'b0, 4'h0}};
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b1, ADR_FXCR, 32'hffffffff);
      wb(1'b0, ADR_FXCR, 32'h0);
      chk(rd, FXCR_MASK);
      wb(1'b1, ADR_MST, 32'h5a5aa5a4);
      wb(1'b0, ADR_MST, 32'h0);
      chk(rd, 32'h5a5aa5a4);
      wb(1'b1, 8'h0c, 32'hffffffff);
      wb(1'b0, 8'h0c, 32'h0);
      chk(rd, 32'h0);
      wb(1'b1, ADR_FXCR, 32'h0);
      wb(1'b1, ADR_MST, 32'h0);
      foreach (emu_tab[k])
      begin
         run(emu_tab[k], 32'h100, 32'h0, 32'h0, 64'h0, 2'b11);
         ex(VEC_EMU);
      end
      run({OP_X, 15'h0, 10'h3d7, 1'b0}, 32'h100, 32'h0, 32'h0, 64'h0, 2'b11);
      chk(exc_o, 1'b0);
      for (i = 0; i < 2; i++)
      begin
         run({OP_X, 15'h0c85, 1'b0, XO_DIVW, 1'b1}, 32'h0, i ? 32'h7 : 32'h80000000,
             i ? 32'h0 : MINUS_ONE, 64'h0, 2'b11);
         chk({res_we_o, res_o, flag_we_o, flag_fld_o, flag_o}, {1'b1, DIV_OVF_RES, 8'h88});
         run({OP_X, 3'h3, 1'b0, i[0], 10'h022, XO_CMP, i[0]}, 32'h0, 32'h1, 32'h2, 64'h0, 2'b11);
         chk({flag_we_o, flag_fld_o, flag_o}, {1'b1, 3'h3, 4'h8});
      end
      for (i = 0; i < 3; i++)
      begin
         run({OP_XL, (i == 1) ? 5'h18 : 5'h10, 10'h0, XO_BCCTR, 1'b0}, 32'h0, 32'h0, 32'h0,
             (i == 2) ? 64'h1 : 64'h9, 2'b11);
         chk({br_v_o, br_taken_o, loopc_o}, {1'b1, i != 2, (i == 2) ? 32'h0 : 32'h8});
      end
      foreach (pr_tab[k])
      begin
         run(pr_tab[k][35:4], 32'h0, 32'h0, 32'h0, 64'h0, pr_tab[k][3:2]);
         chk({pred_v_o, pred_v_o & pred_taken_o}, pr_tab[k][1:0]);
      end
      for (i = 0; i < 2; i++)
      begin
         wb(1'b1, ADR_MST, i ? 32'h0 : 32'h4000);
         run({OP_X, 10'h060, 5'h1f, XO_MFSPR, 1'b0}, 32'h0, 32'h0, 32'h0, 64'h0, 2'b11);
         chk({exc_o, exc_vec_o}, i ? 21'h0 : {1'b1, VEC_PROG});
         run({i ? OP_LFSU : 6'h21, 10'h0a0, 16'h10}, 32'h1234, 32'h0, 32'h0, 64'h3f800000, 2'b11);
         chk({g0_we_o, g0_o}, {1'b1, 32'h1234});
         run(i ? {OP_X, 15'h73d0, XO_LSWI, 1'b0} : {OP_LDM, 10'h39e, 16'h0}, 32'h100, 32'h0,
             32'h0, 64'h0, 2'b11);
         chk({bload_v_o, bload_adr_o}, {1'b1, 32'h108});
      end
      run({OP_LDM, 10'h39e, 16'h0}, 32'h102, 32'h0, 32'h0, 64'h0, 2'b11);
      ex(VEC_ALIGN);
      run({OP_X, 15'h0c85, XO_LWARX, 1'b0}, 32'h101, 32'h0, 32'h0, 64'h0, 2'b11);
      ex(VEC_ALIGN);
      run({OP_LFS, 10'h022, 16'h0}, 32'h100, 32'h0, 32'h0, 64'h1, 2'b11);
      ex(VEC_FPA);
      foreach (fp_tab[k])
      begin
         run({OP_STFS, 10'h022, 16'h0}, 32'h100, 32'h0, 32'h0, fp_tab[k][95:32], 2'b11);
         if (k < 2)
            ex(VEC_FPA);
         else
            chk({exc_o, fst_we_o, fst_o}, {2'b01, fp_tab[k][31:0]});
      end
      wb(1'b1, ADR_MST, 32'h1);
      run({6'h20, 10'h022, 16'h0}, 32'h101, 32'h0, 32'h0, 64'h0, 2'b11);
      ex(VEC_ALIGN);
      run({OP_LDM, 10'h39e, 16'h0}, 32'h100, 32'h0, 32'h0, 64'h0, 2'b11);
      ex(VEC_ALIGN);
      end_sim();
   end

   initial
   begin
      #50000;
      n_fail++;
      end_sim();
   end
endmodule

bind cid_decode cid_sva chk_u (.*);
`default_nettype wire
